// ---- hw/sfmu_pkg.sv ----
// Package for the stack frame and move unit: encodings, widths, reset values.
// Assumes a single 10 MHz clock domain and a decoded instruction stream.
package sfmu_pkg;
  // ****************************************
  // Widths and counts
  // ****************************************
  localparam int GPR_COUNT_LEGACY = 8;
  localparam int GPR_COUNT_WIDE = 16;
  localparam int GPR_IDX_W = 4;
  localparam int SEG_COUNT = 6;
  localparam int SEG_IDX_W = 3;
  localparam int SEG_W = 16;
  localparam int LEGACY_W = 32;
  localparam int WIDE_W = 64;
  localparam int CTL_COUNT = 8;
  localparam int DBG_COUNT = 8;
  localparam int AUX_IDX_W = 3;
  localparam logic [3:0] FRAME_POP_BYTES_32 = 4'h4;
  localparam logic [3:0] FRAME_POP_BYTES_64 = 4'h8;
  localparam logic [63:0] FLAGS_RESET = 64'h0000_0000_0000_0002;
  localparam logic [63:0] IP_RESET = 64'h0000_0000_0000_0000;
  localparam logic [63:0] GPR_RESET = 64'h0000_0000_0000_0000;
  localparam logic [15:0] SEG_RESET = 16'h0000;
  // Flag bit positions
  localparam int FLAG_CARRY = 0;
  localparam int FLAG_PARITY = 2;
  localparam int FLAG_ZERO = 6;
  localparam int FLAG_SIGN = 7;
  localparam int FLAG_OVERFLOW = 11;
  // Stack pointer and frame base indexes
  localparam logic [3:0] GPR_STACK_POINTER = 4'h4;
  localparam logic [3:0] GPR_FRAME_BASE = 4'h5;
  // Feature report bit for conditional move support
  localparam int FEAT_CMOVE_BIT = 15;
  localparam logic [31:0] FEATURE_BASE = 32'h0000_0000;

  // ****************************************
  // Operations and operand kinds
  // ****************************************
  typedef enum logic [3:0] {
    SFMU_OP_NOP, SFMU_OP_FRAME_RELEASE, SFMU_OP_PLAIN_MOVE,
    SFMU_OP_COND_MOVE, SFMU_OP_IDENT_QUERY
  } sfmu_op_t;

  typedef enum logic [2:0] {
    SFMU_LOC_GPR, SFMU_LOC_SEG, SFMU_LOC_MEM, SFMU_LOC_IMM, SFMU_LOC_CTL, SFMU_LOC_DBG
  } sfmu_loc_t;

  // Condition codes; paired aliases share one code
  typedef enum logic [3:0] {
    SFMU_CC_OVERFLOW, SFMU_CC_NO_OVERFLOW, SFMU_CC_BELOW, SFMU_CC_ABOVE_EQ,
    SFMU_CC_EQUAL, SFMU_CC_NOT_EQUAL, SFMU_CC_BELOW_EQ, SFMU_CC_ABOVE,
    SFMU_CC_SIGN, SFMU_CC_NO_SIGN, SFMU_CC_PARITY, SFMU_CC_NO_PARITY,
    SFMU_CC_LESS, SFMU_CC_GREATER_EQ, SFMU_CC_LESS_EQ, SFMU_CC_GREATER
  } sfmu_cc_t;
endpackage : sfmu_pkg

// ---- hw/sfmu_cond_eval.sv ----
// Condition evaluator for the conditional move.
// Assumes flag bits are presented as a 64-bit flags word.
`timescale 1ns/1ps
`default_nettype none
module sfmu_cond_eval (
  input wire logic [63:0] flags,
  input wire sfmu_pkg::sfmu_cc_t cc,
  output logic taken
);
  import sfmu_pkg::*;
  logic carry_flag;
  logic zero_flag;
  logic sign_flag;
  logic overflow_flag;
  logic parity_flag;
  assign carry_flag = flags[FLAG_CARRY];
  assign zero_flag = flags[FLAG_ZERO];
  assign sign_flag = flags[FLAG_SIGN];
  assign overflow_flag = flags[FLAG_OVERFLOW];
  assign parity_flag = flags[FLAG_PARITY];

  // One code per condition, so aliases cannot diverge [RULE_13]
  always_comb begin
    unique case (cc)
      SFMU_CC_OVERFLOW: taken = overflow_flag; // [RULE_16]
      SFMU_CC_NO_OVERFLOW: taken = !overflow_flag;
      SFMU_CC_BELOW: taken = carry_flag; // [RULE_15]
      SFMU_CC_ABOVE_EQ: taken = !carry_flag;
      SFMU_CC_EQUAL: taken = zero_flag;
      SFMU_CC_NOT_EQUAL: taken = !zero_flag;
      SFMU_CC_BELOW_EQ: taken = carry_flag | zero_flag;
      SFMU_CC_ABOVE: taken = !(carry_flag | zero_flag);
      SFMU_CC_SIGN: taken = sign_flag;
      SFMU_CC_NO_SIGN: taken = !sign_flag;
      SFMU_CC_PARITY: taken = parity_flag;
      SFMU_CC_NO_PARITY: taken = !parity_flag;
      SFMU_CC_LESS: taken = sign_flag ^ overflow_flag;
      SFMU_CC_GREATER_EQ: taken = !(sign_flag ^ overflow_flag);
      SFMU_CC_LESS_EQ: taken = (sign_flag ^ overflow_flag) | zero_flag;
      SFMU_CC_GREATER: taken = !((sign_flag ^ overflow_flag) | zero_flag);
    endcase
  end
endmodule : sfmu_cond_eval
`default_nettype wire

// ---- hw/sfmu_top.sv ----
// Stack frame and move unit: architectural registers, frame release,
// plain and conditional moves, identification query.
// Assumes one clock, decoded ops arriving one at a time when ready is high,
// and a memory that answers a read with mem_rvalid some cycles later.
//
// Overview of operation
// RULE_01: Frame release first copies frame base to stack
// RULE_02: Then pops saved frame base from stack
// RULE_03: Eight 32-bit general registers outside wide mode
// RULE_04: Six 16-bit segment registers
// RULE_05: 32-bit flags register outside wide mode
// RULE_06: 32-bit instruction pointer outside wide mode
// RULE_07: Sixteen 64-bit registers, extras need prefix
// RULE_08: Flags and instruction pointer widen to 64
// RULE_09: Plain move supports all listed paths
// RULE_10: No memory-to-memory nor segment-to-segment move
// RULE_11: Conditional move copies 16/32-bit value when true
// RULE_12: False condition leaves destination unchanged
// RULE_13: Paired condition names decode identically
// RULE_14: Identification query reports conditional move support
// RULE_15: Unsigned and parity condition equations
// RULE_16: Signed, overflow and sign condition equations
// RULE_17: 32-bit frame pop reads dword, adds four
`timescale 1ns/1ps
`default_nettype none
module sfmu_top #(
  parameter bit CMOVE_PRESENT = 1'b1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic op_valid,
  input wire sfmu_pkg::sfmu_op_t op_code,
  input wire logic wide_mode,
  input wire logic ext_prefix,
  input wire logic [1:0] op_size,
  input wire sfmu_pkg::sfmu_loc_t src_kind,
  input wire sfmu_pkg::sfmu_loc_t dst_kind,
  input wire logic [3:0] src_idx,
  input wire logic [3:0] dst_idx,
  input wire sfmu_pkg::sfmu_cc_t cond_code,
  input wire logic [63:0] imm_data,
  input wire logic [63:0] mem_addr_in,
  input wire logic [63:0] next_ip,
  input wire logic [63:0] mem_rdata,
  input wire logic mem_rvalid,
  output logic op_ready,
  output logic op_done,
  output logic op_fault,
  output logic mem_rd,
  output logic mem_wr,
  output logic [63:0] mem_addr,
  output logic [63:0] mem_wdata,
  output logic [31:0] feature_info,
  output logic [63:0] flags_out,
  output logic [63:0] ip_out
);
  import sfmu_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [1:0] {SFMU_IDLE, SFMU_POP_WAIT, SFMU_LOAD_WAIT} sfmu_state_t;
  typedef struct packed {
    sfmu_state_t st;
    logic [GPR_COUNT_WIDE-1:0][WIDE_W-1:0] gpr;
    logic [SEG_COUNT-1:0][SEG_W-1:0] seg;
    logic [CTL_COUNT-1:0][WIDE_W-1:0] ctl;
    logic [DBG_COUNT-1:0][WIDE_W-1:0] dbg;
    logic [WIDE_W-1:0] flags;
    logic [WIDE_W-1:0] ip;
    logic wide;
    logic [3:0] pend_idx;
    logic pend_seg;
    logic [1:0] pend_size;
    logic ready;
    logic done;
    logic fault;
    logic rd;
    logic wr;
    logic [63:0] addr;
    logic [63:0] wdata;
    logic [31:0] feat;
  } sfmu_regs_t;

  sfmu_regs_t r;
  sfmu_regs_t next_r;
  logic rst_meta;
  logic rst_sync;
  logic cc_taken;
  logic [63:0] src_val;
  logic [3:0] eff_src;
  logic [3:0] eff_dst;
  logic bad_idx;
  logic [63:0] pop_step;

  // ****************************************
  // Reset release
  // ****************************************
  // Two flops so release is clean to the clock
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  sfmu_cond_eval u_cond (
    .flags(r.flags),
    .cc(cond_code),
    .taken(cc_taken)
  );

  // Upper eight registers reachable only with the prefix in wide mode
  assign eff_src = (wide_mode && ext_prefix) ? src_idx : {1'b0, src_idx[2:0]}; // [RULE_07] [RULE_03]
  assign eff_dst = (wide_mode && ext_prefix) ? dst_idx : {1'b0, dst_idx[2:0]};
  assign bad_idx = (src_kind == SFMU_LOC_SEG && src_idx >= 4'(SEG_COUNT)) ||
                   (dst_kind == SFMU_LOC_SEG && dst_idx >= 4'(SEG_COUNT)); // [RULE_04]
  assign pop_step = r.wide ? 64'(FRAME_POP_BYTES_64) : 64'(FRAME_POP_BYTES_32); // [RULE_17]

  // Source operand fetch for register and immediate sources
  always_comb begin
    src_val = 64'h0;
    unique case (src_kind)
      SFMU_LOC_GPR: src_val = r.gpr[eff_src];
      SFMU_LOC_SEG: src_val = 64'(r.seg[src_idx[SEG_IDX_W-1:0]]);
      SFMU_LOC_IMM: src_val = imm_data;
      SFMU_LOC_CTL: src_val = r.ctl[src_idx[AUX_IDX_W-1:0]];
      SFMU_LOC_DBG: src_val = r.dbg[src_idx[AUX_IDX_W-1:0]];
      SFMU_LOC_MEM: src_val = 64'h0;
    endcase
  end

  // Write a value into a general register, sized by op_size
  function automatic logic [63:0] sfmu_merge(input logic [63:0] old, input logic [63:0] val,
                                             input logic [1:0] sz);
    logic [63:0] res;
    res = old;
    unique case (sz)
      2'h0: res[7:0] = val[7:0];
      2'h1: res[15:0] = val[15:0];
      2'h2: res = {32'h0, val[31:0]};
      2'h3: res = val;
    endcase
    return res;
  endfunction : sfmu_merge

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    next_r.fault = 1'b0;
    next_r.rd = 1'b0;
    next_r.wr = 1'b0;
    // Narrow modes keep only 32 bits of flags and pointer [RULE_05] [RULE_06] [RULE_08]
    if (!wide_mode) begin
      next_r.flags[63:32] = 32'h0;
      next_r.ip[63:32] = 32'h0;
    end
    next_r.feat = FEATURE_BASE;
    next_r.feat[FEAT_CMOVE_BIT] = CMOVE_PRESENT;
    unique case (r.st)
      SFMU_IDLE: begin
        if (op_valid && r.ready) begin
          next_r.ip = wide_mode ? next_ip : {32'h0, next_ip[31:0]};
          next_r.wide = wide_mode; // Mode of the op, kept while its pop is pending
          unique case (op_code)
            SFMU_OP_FRAME_RELEASE: begin
              // Stack pointer takes frame base, then pop old base [RULE_01] [RULE_02]
              next_r.gpr[GPR_STACK_POINTER] = r.gpr[GPR_FRAME_BASE];
              next_r.rd = 1'b1;
              next_r.addr = r.gpr[GPR_FRAME_BASE];
              next_r.ready = 1'b0;
              next_r.st = SFMU_POP_WAIT;
            end
            SFMU_OP_PLAIN_MOVE: begin
              // Mem-to-mem and seg-to-seg are illegal [RULE_10]
              if ((src_kind == SFMU_LOC_MEM && dst_kind == SFMU_LOC_MEM) ||
                  (src_kind == SFMU_LOC_SEG && dst_kind == SFMU_LOC_SEG) || bad_idx ||
                  dst_kind == SFMU_LOC_IMM ||
                  ((src_kind inside {SFMU_LOC_CTL, SFMU_LOC_DBG}) && dst_kind != SFMU_LOC_GPR) ||
                  ((dst_kind inside {SFMU_LOC_CTL, SFMU_LOC_DBG}) && src_kind != SFMU_LOC_GPR)) begin
                next_r.fault = 1'b1;
                next_r.done = 1'b1;
              end else if (src_kind == SFMU_LOC_MEM) begin // [RULE_09]
                next_r.rd = 1'b1;
                next_r.addr = mem_addr_in;
                next_r.pend_idx = eff_dst;
                next_r.pend_seg = (dst_kind == SFMU_LOC_SEG);
                next_r.pend_size = op_size;
                next_r.ready = 1'b0;
                next_r.st = SFMU_LOAD_WAIT;
              end else if (dst_kind == SFMU_LOC_MEM) begin
                next_r.wr = 1'b1;
                next_r.addr = mem_addr_in;
                next_r.wdata = src_val;
                next_r.done = 1'b1;
              end else begin
                unique case (dst_kind)
                  SFMU_LOC_GPR: next_r.gpr[eff_dst] = sfmu_merge(r.gpr[eff_dst], src_val, op_size);
                  SFMU_LOC_SEG: next_r.seg[dst_idx[SEG_IDX_W-1:0]] = src_val[SEG_W-1:0];
                  SFMU_LOC_CTL: next_r.ctl[dst_idx[AUX_IDX_W-1:0]] = src_val;
                  SFMU_LOC_DBG: next_r.dbg[dst_idx[AUX_IDX_W-1:0]] = src_val;
                  default: next_r.fault = 1'b1;
                endcase
                next_r.done = 1'b1;
              end
            end
            SFMU_OP_COND_MOVE: begin
              // Only general or memory source into general register [RULE_11]
              if (dst_kind != SFMU_LOC_GPR || !(src_kind inside {SFMU_LOC_GPR, SFMU_LOC_MEM}) ||
                  op_size == 2'h0) begin
                next_r.fault = 1'b1;
                next_r.done = 1'b1;
              end else if (!cc_taken) begin
                next_r.done = 1'b1; // Destination untouched [RULE_12]
              end else if (src_kind == SFMU_LOC_MEM) begin
                next_r.rd = 1'b1;
                next_r.addr = mem_addr_in;
                next_r.pend_idx = eff_dst;
                next_r.pend_seg = 1'b0;
                next_r.pend_size = op_size;
                next_r.ready = 1'b0;
                next_r.st = SFMU_LOAD_WAIT;
              end else begin
                next_r.gpr[eff_dst] = sfmu_merge(r.gpr[eff_dst], src_val, op_size);
                next_r.done = 1'b1;
              end
            end
            SFMU_OP_IDENT_QUERY: begin
              next_r.done = 1'b1; // Feature word on feature_info from the first clock after reset release [RULE_14]
            end
            default: next_r.done = 1'b1;
          endcase
        end
      end
      SFMU_POP_WAIT: begin
        if (mem_rvalid) begin
          // Old base restored, stack pointer past the slot [RULE_02] [RULE_17]
          next_r.gpr[GPR_FRAME_BASE] = r.wide ? mem_rdata : {32'h0, mem_rdata[31:0]};
          next_r.gpr[GPR_STACK_POINTER] = r.gpr[GPR_STACK_POINTER] + pop_step;
          next_r.ready = 1'b1;
          next_r.done = 1'b1;
          next_r.st = SFMU_IDLE;
        end
      end
      SFMU_LOAD_WAIT: begin
        if (mem_rvalid) begin
          if (r.pend_seg) begin
            next_r.seg[r.pend_idx[SEG_IDX_W-1:0]] = mem_rdata[SEG_W-1:0];
          end else begin
            next_r.gpr[r.pend_idx] = sfmu_merge(r.gpr[r.pend_idx], mem_rdata, r.pend_size);
          end
          next_r.ready = 1'b1;
          next_r.done = 1'b1;
          next_r.st = SFMU_IDLE;
        end
      end
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      r <= '0;
      r.st <= SFMU_IDLE;
      r.flags <= FLAGS_RESET;
      r.ip <= IP_RESET;
      r.ready <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign op_ready = r.ready;
  assign op_done = r.done;
  assign op_fault = r.fault;
  assign mem_rd = r.rd;
  assign mem_wr = r.wr;
  assign mem_addr = r.addr;
  assign mem_wdata = r.wdata;
  assign feature_info = r.feat;
  assign flags_out = r.flags;
  assign ip_out = r.ip;

  // ****************************************
  // Checks
  // ****************************************
  chk_release_sp_load: assert property (@(posedge clk) disable iff (!rst_sync) // [RULE_01]
    (r.st == SFMU_IDLE && r.ready && op_valid && op_code == SFMU_OP_FRAME_RELEASE)
    |=> (r.gpr[GPR_STACK_POINTER] == $past(r.gpr[GPR_FRAME_BASE]) && r.rd))
    else $error("frame release did not load stack pointer");
  chk_release_pop: assert property (@(posedge clk) disable iff (!rst_sync) // [RULE_02]
    (r.st == SFMU_POP_WAIT && mem_rvalid && !r.wide) |=> (r.gpr[GPR_FRAME_BASE] == {32'h0, $past(mem_rdata[31:0])}))
    else $error("frame base not restored");
  chk_pop_step: assert property (@(posedge clk) disable iff (!rst_sync) // [RULE_17]
    (r.st == SFMU_POP_WAIT && mem_rvalid && !r.wide)
    |=> (r.gpr[GPR_STACK_POINTER] == $past(r.gpr[GPR_STACK_POINTER]) + 64'h4))
    else $error("pop did not advance stack pointer by four");
  chk_narrow_flags: assert property (@(posedge clk) disable iff (!rst_sync) // [RULE_05]
    $past(!wide_mode) |-> (r.flags[63:32] == 32'h0 && r.ip[63:32] == 32'h0))
    else $error("narrow mode flags or pointer wider than 32 bits");
  chk_mem_to_mem: assert property (@(posedge clk) disable iff (!rst_sync) // [RULE_10]
    (r.st == SFMU_IDLE && r.ready && op_valid && op_code == SFMU_OP_PLAIN_MOVE &&
     src_kind == SFMU_LOC_MEM && dst_kind == SFMU_LOC_MEM) |=> (r.fault && !r.rd && !r.wr))
    else $error("memory to memory move not refused");
  chk_cond_false: assert property (@(posedge clk) disable iff (!rst_sync) // [RULE_12]
    (r.st == SFMU_IDLE && r.ready && op_valid && op_code == SFMU_OP_COND_MOVE && !cc_taken)
    |=> (r.gpr == $past(r.gpr) && r.done))
    else $error("false conditional move changed a register");
  chk_cond_true: assert property (@(posedge clk) disable iff (!rst_sync) // [RULE_11]
    (r.st == SFMU_IDLE && r.ready && op_valid && op_code == SFMU_OP_COND_MOVE && cc_taken &&
     src_kind == SFMU_LOC_GPR && dst_kind == SFMU_LOC_GPR && op_size == 2'h2)
    |=> (r.gpr[$past(eff_dst)][31:0] == $past(src_val[31:0])))
    else $error("true conditional move did not copy");
  chk_feature_bit: assert property (@(posedge clk) disable iff (!rst_sync) // [RULE_14]
    $past(rst_sync) |-> (feature_info[FEAT_CMOVE_BIT] == CMOVE_PRESENT))
    else $error("feature bit wrong");
  chk_ext_gated: assert property (@(posedge clk) disable iff (!rst_sync) // [RULE_07]
    (!wide_mode || !ext_prefix) |-> !eff_dst[3])
    else $error("upper register reached without prefix");
  cov_release: cover property (@(posedge clk) disable iff (!rst_sync)
    (r.st == SFMU_POP_WAIT) ##[1:20] (r.st == SFMU_IDLE && r.done));
  cov_cond_taken: cover property (@(posedge clk) disable iff (!rst_sync)
    (op_valid && op_code == SFMU_OP_COND_MOVE && cc_taken && r.ready));
  cov_cond_skip: cover property (@(posedge clk) disable iff (!rst_sync)
    (op_valid && op_code == SFMU_OP_COND_MOVE && !cc_taken && r.ready));
  cov_store: cover property (@(posedge clk) disable iff (!rst_sync) r.wr);
endmodule : sfmu_top
`default_nettype wire

// ---- dv/sfmu_mem_model.sv ----
// Behavioural memory standing behind the stack frame and move unit.
// Assumes single-cycle stores and reads answered lat cycles after mem_rd.
`timescale 1ns/1ps
`default_nettype none
module sfmu_mem_model (
  input wire logic clk,
  input wire logic [3:0] lat,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [63:0] mem_addr,
  input wire logic [63:0] mem_wdata,
  output logic [63:0] mem_rdata,
  output logic mem_rvalid
);
  logic [63:0] store [logic [63:0]];
  logic [63:0] pend_addr;
  logic busy;
  int unsigned wait_cnt;

  // ****************************************
  // Storage and read answer
  // ****************************************
  initial begin
    mem_rvalid = 1'b0;
    mem_rdata = 64'h0;
    busy = 1'b0;
    wait_cnt = 0;
    pend_addr = 64'h0;
  end

  // Read data toggles outside the answer cycle, so a sample one cycle late never matches
  always @(posedge clk) begin
    mem_rvalid <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_wr === 1'b1) begin
      store[mem_addr] = mem_wdata;
    end
    if (busy) begin
      if (wait_cnt <= 1) begin
        busy <= 1'b0;
        mem_rvalid <= 1'b1;
        mem_rdata <= store.exists(pend_addr) ? store[pend_addr] : {pend_addr[31:0], ~pend_addr[31:0]};
      end else begin
        wait_cnt <= wait_cnt - 1;
      end
    end else if (mem_rd === 1'b1) begin
      busy <= 1'b1;
      pend_addr <= mem_addr;
      wait_cnt <= lat;
    end
  end
endmodule : sfmu_mem_model
`default_nettype wire

// ---- dv/tb.sv ----
// Self-checking bench for the stack frame and move unit.
// Assumes register contents other than flags and pointer are seen only through stores to memory.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sfmu_pkg::*;
  logic clk = 0, nrst = 0, op_valid = 0, wide_mode = 0, ext_prefix = 0;
  logic op_ready, op_done, op_fault, mem_rd, mem_wr, mem_rvalid;
  logic [1:0] op_size = 2'h0;
  logic [3:0] src_idx = 4'h0, dst_idx = 4'h0, lat = 4'h1;
  logic [63:0] imm_data = 64'h0, mem_addr_in = 64'h0, next_ip = 64'hfedc_ba98_7654_3210;
  logic [63:0] mem_rdata, mem_addr, mem_wdata, flags_out, ip_out, wd, wa, ra;
  logic [31:0] feature_info;
  sfmu_op_t op_code = SFMU_OP_NOP;
  sfmu_loc_t src_kind = SFMU_LOC_GPR, dst_kind = SFMU_LOC_GPR;
  sfmu_cc_t cond_code = SFMU_CC_OVERFLOW;
  logic saw_wr, saw_rd, flt, done;
  int miscompares = 0, comparisons = 0;

  // ****************************************
  // Clock, design and memory
  // ****************************************
  always #50 clk = ~clk;

  sfmu_top uut (.clk(clk), .nrst(nrst), .op_valid(op_valid), .op_code(op_code), .wide_mode(wide_mode),
    .ext_prefix(ext_prefix), .op_size(op_size), .src_kind(src_kind), .dst_kind(dst_kind), .src_idx(src_idx),
    .dst_idx(dst_idx), .cond_code(cond_code), .imm_data(imm_data), .mem_addr_in(mem_addr_in),
    .next_ip(next_ip), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid), .op_ready(op_ready),
    .op_done(op_done), .op_fault(op_fault), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .feature_info(feature_info), .flags_out(flags_out), .ip_out(ip_out));

  sfmu_mem_model mem_i (.clk(clk), .lat(lat), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // One request, driven for one cycle once ready is seen; memory activity gathered up to done
  task automatic op(input sfmu_op_t oc, input sfmu_loc_t sk, input sfmu_loc_t dk, input logic [3:0] si,
                    input logic [3:0] di, input logic [1:0] sz, input logic [63:0] imm,
                    input logic [63:0] a = 64'h40, input sfmu_cc_t cc = SFMU_CC_OVERFLOW);
    int n;
    n = 0;
    saw_wr = 0;
    saw_rd = 0;
    flt = 0;
    done = 0;
    while (op_ready !== 1'b1 && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    op_valid <= 1'b1;
    op_code <= oc;
    src_kind <= sk;
    dst_kind <= dk;
    src_idx <= si;
    dst_idx <= di;
    op_size <= sz;
    imm_data <= imm;
    mem_addr_in <= a;
    cond_code <= cc;
    @(posedge clk);
    op_valid <= 1'b0;
    n = 0;
    while (!done && n < 60) begin
      #1;
      if (mem_wr === 1'b1) begin
        saw_wr = 1;
        wd = mem_wdata;
        wa = mem_addr;
      end
      if (mem_rd === 1'b1) begin
        saw_rd = 1;
        ra = mem_addr;
        chk("ready while reading", 64'h0, {63'h0, op_ready});
      end
      if (op_done === 1'b1) begin
        done = 1;
        flt = op_fault;
      end else begin
        @(posedge clk);
      end
      n++;
    end
    chk("op_done", 64'h1, {63'h0, done});
  endtask : op

  task automatic ld(input logic [3:0] i, input logic [1:0] sz, input logic [63:0] v);
    op(SFMU_OP_PLAIN_MOVE, SFMU_LOC_IMM, SFMU_LOC_GPR, 4'h0, i, sz, v);
  endtask : ld

  // Store a register and compare the low 64 bits for size 3, 32 bits for size 2, and 16 bits for any smaller size
  task automatic st(input sfmu_loc_t sk, input logic [3:0] i, input logic [1:0] sz, input logic [63:0] e,
                    input string n);
    logic [63:0] m;
    m = (sz == 2'h3) ? 64'hffff_ffff_ffff_ffff : (sz == 2'h2) ? 64'hffff_ffff : 64'hffff;
    op(SFMU_OP_PLAIN_MOVE, sk, SFMU_LOC_MEM, i, 4'h0, sz, 64'h0, 64'h48);
    chk({n, " store"}, 64'h1, {63'h0, saw_wr});
    chk({n, " addr"}, 64'h48, wa);
    chk(n, e & m, wd & m);
  endtask : st

  task automatic refused(input sfmu_loc_t sk, input sfmu_loc_t dk, input logic [3:0] si, input string n);
    op(SFMU_OP_PLAIN_MOVE, sk, dk, si, 4'h1, 2'h1, 64'h0);
    chk({n, " fault"}, 64'h1, {63'h0, flt});
    chk({n, " no access"}, 64'h0, {62'h0, saw_rd, saw_wr});
  endtask : refused

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    chk("flags", FLAGS_RESET, flags_out);
    chk("ip", IP_RESET, ip_out);
    chk("cmove feature", 64'h1, {63'h0, feature_info[FEAT_CMOVE_BIT]});
  endtask : t_reset

  task automatic t_legacy_regs;
    for (int i = 0; i < GPR_COUNT_LEGACY; i++) ld(4'(i), 2'h2, 64'hffff_ffff_8000_0010 + 64'(i));
    for (int i = 0; i < GPR_COUNT_LEGACY; i++) st(SFMU_LOC_GPR, 4'(i), 2'h2, 64'h8000_0010 + 64'(i), "gpr");
    chk("ip legacy", {32'h0, next_ip[31:0]}, ip_out);
  endtask : t_legacy_regs

  // Segment, control, debug and memory paths plus the forbidden ones
  task automatic t_paths;
    ld(4'h2, 2'h2, 64'hbeef_1234);
    op(SFMU_OP_PLAIN_MOVE, SFMU_LOC_GPR, SFMU_LOC_SEG, 4'h2, 4'h5, 2'h1, 64'h0);
    st(SFMU_LOC_SEG, 4'h5, 2'h1, 64'h1234, "seg");
    op(SFMU_OP_PLAIN_MOVE, SFMU_LOC_SEG, SFMU_LOC_GPR, 4'h5, 4'h3, 2'h1, 64'h0);
    st(SFMU_LOC_GPR, 4'h3, 2'h1, 64'h1234, "seg to gpr");
    op(SFMU_OP_PLAIN_MOVE, SFMU_LOC_GPR, SFMU_LOC_CTL, 4'h2, 4'h3, 2'h2, 64'h0);
    op(SFMU_OP_PLAIN_MOVE, SFMU_LOC_CTL, SFMU_LOC_GPR, 4'h3, 4'h6, 2'h2, 64'h0);
    st(SFMU_LOC_GPR, 4'h6, 2'h2, 64'hbeef_1234, "ctl");
    op(SFMU_OP_PLAIN_MOVE, SFMU_LOC_GPR, SFMU_LOC_DBG, 4'h2, 4'h1, 2'h2, 64'h0);
    op(SFMU_OP_PLAIN_MOVE, SFMU_LOC_DBG, SFMU_LOC_GPR, 4'h1, 4'h7, 2'h2, 64'h0);
    st(SFMU_LOC_GPR, 4'h7, 2'h2, 64'hbeef_1234, "dbg");
    op(SFMU_OP_PLAIN_MOVE, SFMU_LOC_IMM, SFMU_LOC_MEM, 4'h0, 4'h0, 2'h2, 64'h7777_abcd, 64'h60);
    op(SFMU_OP_PLAIN_MOVE, SFMU_LOC_MEM, SFMU_LOC_GPR, 4'h0, 4'h1, 2'h2, 64'h0, 64'h60);
    st(SFMU_LOC_GPR, 4'h1, 2'h2, 64'h7777_abcd, "mem to gpr");
    refused(SFMU_LOC_MEM, SFMU_LOC_MEM, 4'h0, "mem to mem");
    refused(SFMU_LOC_SEG, SFMU_LOC_SEG, 4'h5, "seg to seg");
    refused(SFMU_LOC_SEG, SFMU_LOC_GPR, 4'h6, "seg index");
  endtask : t_paths

  // Frame release with the saved base preloaded at the frame base address
  task automatic t_frame(input logic w, input logic [3:0] l, input logic [63:0] base, input logic [63:0] v);
    logic [1:0] sz;
    sz = w ? 2'h3 : 2'h2;
    ld(GPR_FRAME_BASE, sz, base);
    ld(GPR_STACK_POINTER, sz, 64'h80);
    op(SFMU_OP_PLAIN_MOVE, SFMU_LOC_IMM, SFMU_LOC_MEM, 4'h0, 4'h0, 2'h3, v, base);
    lat = l;
    op(SFMU_OP_FRAME_RELEASE, SFMU_LOC_GPR, SFMU_LOC_GPR, 4'h0, 4'h0, sz, 64'h0);
    chk("pop issued", 64'h1, {63'h0, saw_rd});
    chk("pop read", base, ra);
    chk("no fault", 64'h0, {63'h0, flt});
    st(SFMU_LOC_GPR, GPR_STACK_POINTER, sz, base + (w ? 64'h8 : 64'h4), "stack after");
    st(SFMU_LOC_GPR, GPR_FRAME_BASE, sz, v, "frame base after");
  endtask : t_frame

  // Flags stay at reset, so odd condition codes hold and even ones fail
  task automatic t_cmove;
    for (int c = 0; c < 16; c++) begin
      ld(4'h2, 2'h2, 64'h1111_0000 + 64'(c));
      ld(4'h3, 2'h2, 64'h2222_0000 + 64'(c));
      op(SFMU_OP_COND_MOVE, SFMU_LOC_GPR, SFMU_LOC_GPR, 4'h3, 4'h2, 2'h2, 64'h0, 64'h40, sfmu_cc_t'(c));
      st(SFMU_LOC_GPR, 4'h2, 2'h2, (c % 2) ? 64'h2222_0000 + 64'(c) : 64'h1111_0000 + 64'(c), "cmove");
    end
    op(SFMU_OP_COND_MOVE, SFMU_LOC_MEM, SFMU_LOC_GPR, 4'h0, 4'h2, 2'h1, 64'h0, 64'h60, SFMU_CC_NO_SIGN);
    st(SFMU_LOC_GPR, 4'h2, 2'h1, 64'habcd, "cmove mem");
    op(SFMU_OP_COND_MOVE, SFMU_LOC_GPR, SFMU_LOC_GPR, 4'h3, 4'h2, 2'h0, 64'h0, 64'h40, SFMU_CC_NO_SIGN);
    chk("cmove byte fault", 64'h1, {63'h0, flt});
  endtask : t_cmove

  task automatic t_wide;
    @(posedge clk);
    wide_mode <= 1'b1;
    ext_prefix <= 1'b1;
    ld(4'h9, 2'h3, 64'h1122_3344_5566_7788);
    st(SFMU_LOC_GPR, 4'h9, 2'h3, 64'h1122_3344_5566_7788, "extra gpr");
    @(posedge clk);
    ext_prefix <= 1'b0;
    ld(4'h9, 2'h3, 64'h99aa_bbcc_ddee_ff00);
    st(SFMU_LOC_GPR, 4'h1, 2'h3, 64'h99aa_bbcc_ddee_ff00, "no prefix");
    chk("ip wide", next_ip, ip_out);
    chk("flags wide", FLAGS_RESET, flags_out);
  endtask : t_wide

  task automatic report_and_stop;
    if (miscompares == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    t_reset();
    t_legacy_regs();
    t_paths();
    t_frame(1'b0, 4'h1, 64'h100, 64'h5a5a_5a5a_dead_beef);
    t_cmove();
    t_wide();
    t_frame(1'b1, 4'h6, 64'h200, 64'h0123_4567_89ab_cdef);
    report_and_stop();
  end

  // Whole run needs well under 3000 cycles
  initial begin
    #1_000_000;
    miscompares++;
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
